// ==== rtl/ubia_pkg.sv ====
// Behaviour
// R1: Each bid is 12 bits: level or priority, type code, index bit.
// R2: Receiver bids carry fill count; type 001 clean, 101 error, 100 watchdog.
// R3: Transmitter bid carries empty-location count with type 010.
// R4: Sources without queue bid with a seven-bit priority and fixed four-bit codes.
// R5: Request is asserted while an enabled bid exceeds the threshold times sixteen.
// R6: Only mask-enabled sources take part in arbitration and capture.
// R7: Arbitration runs every second clock, one new winner per two cycles.
// R8: A bid changing mid-arbitration counts only in the next arbitration.
// R9: Acknowledge falling or update command latches the current winner.
// R10: Captured value holds until the next acknowledge or update command.
// R11: With no winner the capture loads zero, giving zero vector bits.
// R12: Acknowledge drives the vector, optionally with type and channel inserted.
// R13: Nine global registers are decoded from the captured value; GSTM instead returns the masked active-source status.
// R14: Global byte count returns the level of the captured source's queue.
// R15: Global channel reads zero except counter 1 or port group 1.
// R16: Global receive port returns data from the winning receive queue.
// R17: Host acknowledges or updates the capture before reading it.
// R18: Polling host sets threshold zero, updates, reads, stops on zero.
// R19: Break change is flagged at break start and again at break end.
// R20: Queue bidding starts only once the programmed trigger level is met; the watchdog bid follows its timeout flag regardless of level.
// R21: Request deasserts within one arbitration cycle once no bid qualifies.
package ubia_pkg;
  localparam int UBIA_NSRC = 10;
  localparam int UBIA_BIDW = 12;
  localparam int UBIA_AW   = 7;
  localparam logic [8:0] UBIA_QDEPTH = 9'h100;
  localparam logic [8:0] UBIA_QHALF  = 9'h080;
  localparam logic [8:0] UBIA_Q3Q    = 9'h0c0;
  localparam logic       UBIA_CHAN   = 1'h0;
  // ----------------------------------------------------------------------
  // Register offsets.
  // ----------------------------------------------------------------------
  localparam logic [6:0] UBIA_A_CTRL   = 7'h00;
  localparam logic [6:0] UBIA_A_MASK   = 7'h04;
  localparam logic [6:0] UBIA_A_STAT   = 7'h08;
  localparam logic [6:0] UBIA_A_CAP    = 7'h0c;
  localparam logic [6:0] UBIA_A_UPD    = 7'h10;
  localparam logic [6:0] UBIA_A_VEC    = 7'h14;
  localparam logic [6:0] UBIA_A_PRIOA  = 7'h18;
  localparam logic [6:0] UBIA_A_PRIOB  = 7'h1c;
  localparam logic [6:0] UBIA_A_TRIG   = 7'h20;
  localparam logic [6:0] UBIA_A_GBC    = 7'h40;
  localparam logic [6:0] UBIA_A_GCH    = 7'h44;
  localparam logic [6:0] UBIA_A_GCHA   = 7'h48;
  localparam logic [6:0] UBIA_A_GTYP   = 7'h4c;
  localparam logic [6:0] UBIA_A_GRX    = 7'h50;
  localparam logic [6:0] UBIA_A_GTX    = 7'h54;
  localparam logic [6:0] UBIA_A_GCNT   = 7'h58;
  localparam logic [6:0] UBIA_A_GVEC   = 7'h5c;
  localparam logic [6:0] UBIA_A_GCAP   = 7'h60;
  localparam logic [6:0] UBIA_A_GSTM   = 7'h64;
  // ----------------------------------------------------------------------
  // Source indices and codes.
  // ----------------------------------------------------------------------
  localparam int UBIA_S_RXOK = 0;
  localparam int UBIA_S_RXER = 1;
  localparam int UBIA_S_RXWD = 2;
  localparam int UBIA_S_TX   = 3;
  localparam int UBIA_S_BRK  = 4;
  localparam int UBIA_S_LPB  = 5;
  localparam int UBIA_S_COS  = 6;
  localparam int UBIA_S_XON  = 7;
  localparam int UBIA_S_CT   = 8;
  localparam int UBIA_S_ADR  = 9;
  localparam logic [2:0] UBIA_T_RXOK = 3'h1;
  localparam logic [2:0] UBIA_T_RXER = 3'h5;
  localparam logic [2:0] UBIA_T_RXWD = 3'h4;
  localparam logic [2:0] UBIA_T_TX   = 3'h2;
  localparam logic [3:0] UBIA_C_BRK  = 4'he;
  localparam logic [3:0] UBIA_C_LPB  = 4'hf;
  localparam logic [3:0] UBIA_C_COS  = 4'h6;
  localparam logic [3:0] UBIA_C_XON  = 4'h7;
  localparam logic [3:0] UBIA_C_CT   = 4'h8;
  localparam logic [3:0] UBIA_C_ADR  = 4'hb;
  localparam logic [9:0] UBIA_EVT_MASK = 10'h3f4;
  localparam logic [7:0] UBIA_VEC_RST  = 8'h00;

  // Saturates a queue count of 0..256 into eight bits.
  function automatic logic [7:0] ubia_sat8(input logic [8:0] c);
    ubia_sat8 = c[8] ? 8'hff : c[7:0];
  endfunction : ubia_sat8

  // Trigger levels: 0 any, 1 half, 2 three quarters, 3 whole queue.
  function automatic logic ubia_trig(input logic [1:0] lvl, input logic [8:0] c);
    case (lvl)
      2'h0:    ubia_trig = (c != 9'h000);
      2'h1:    ubia_trig = (c >= UBIA_QHALF);
      2'h2:    ubia_trig = (c >= UBIA_Q3Q);
      default: ubia_trig = (c >= UBIA_QDEPTH);
    endcase
  endfunction : ubia_trig
endpackage : ubia_pkg

// ==== rtl/ubia_bid_max.sv ====
`timescale 1ns/1ps
module ubia_bid_max #(
  parameter int N = 10,
  parameter int W = 12
) (
  input  wire logic [N-1:0][W-1:0] bids,
  input  wire logic [N-1:0]        valid,
  input  wire logic [7:0]          threshold,
  output logic      [W-1:0]        max_bid,
  output logic                     hit
);
  import ubia_pkg::*;

  // ----------------------------------------------------------------------
  // Highest enabled bid above the threshold.
  // ----------------------------------------------------------------------
  logic [W-1:0] thr_w;
  assign thr_w = W'({threshold, 4'h0});

  always_comb begin
    max_bid = '0;
    for (int i = 0; i < N; i++) begin
      if (valid[i] && bids[i] > thr_w && bids[i] > max_bid) begin // [R5] [R6]
        max_bid = bids[i];
      end
    end
    hit = (max_bid != '0);
  end
endmodule : ubia_bid_max

// ==== rtl/ubia_top.sv ====
`timescale 1ns/1ps
module ubia_top (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic [ubia_pkg::UBIA_AW-1:0] avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  output logic                          interrupt_request_n,
  input  wire logic                     interrupt_ack_n,
  output logic      [7:0]               vector_out,
  output logic                          vector_oe,
  input  wire logic [8:0]               rx_fill,
  input  wire logic                     rx_error_present,
  input  wire logic                     rx_timeout_evt,
  input  wire logic [7:0]               rx_data,
  output logic                          rx_pop,
  input  wire logic [8:0]               tx_empty,
  output logic                          tx_push,
  output logic      [7:0]               tx_wdata,
  input  wire logic                     break_level,
  input  wire logic                     loopback_err_evt,
  input  wire logic                     cos_evt,
  input  wire logic                     cos_port,
  input  wire logic                     xon_evt,
  input  wire logic                     ct_evt,
  input  wire logic                     ct_index,
  input  wire logic                     addr_evt
);
  import ubia_pkg::*;

  typedef struct packed {
    logic                                    bus_ack;
    logic [31:0]                             rdata;
    logic [7:0]                              thr;
    logic                                    vm_type;
    logic                                    vm_chan;
    logic [UBIA_NSRC-1:0]                    mask;
    logic [UBIA_NSRC-1:0]                    evt;
    logic [UBIA_BIDW-1:0]                    cap;
    logic [7:0]                              vec;
    logic [5:0][6:0]                         prio;
    logic [1:0]                              rx_trig;
    logic [1:0]                              tx_trig;
    logic                                    phase;
    logic [UBIA_NSRC-1:0]                    snap_v;
    logic [UBIA_NSRC-1:0][UBIA_BIDW-1:0]     snap_b;
    logic [UBIA_BIDW-1:0]                    win;
    logic                                    irq;
    logic                                    brk_prev;
    logic                                    ack_s1;
    logic                                    ack_s2;
    logic                                    ack_s3;
    logic                                    ack_act;
    logic                                    cos_idx;
    logic                                    ct_idx;
    logic [7:0]                              vec_out;
    logic [7:0]                              wdat;
  } ubia_state_s;

  ubia_state_s r_r;
  ubia_state_s r_nxt;

  logic [UBIA_BIDW-1:0]                arb_max;
  logic                                arb_hit;
  logic [UBIA_NSRC-1:0][UBIA_BIDW-1:0] bids;
  logic [UBIA_NSRC-1:0]                active;

  // ----------------------------------------------------------------------
  // Captured value decoding.
  // ----------------------------------------------------------------------
  function automatic logic cap_is_rx(input logic [UBIA_BIDW-1:0] c);
    cap_is_rx = (c[3:1] == UBIA_T_RXOK) || (c[3:1] == UBIA_T_RXER)
             || (c[3:1] == UBIA_T_RXWD);
  endfunction : cap_is_rx

  function automatic logic [7:0] mod_vec(input logic [7:0] v, input logic [UBIA_BIDW-1:0] c,
                                         input logic mt, input logic mc);
    mod_vec = v;
    if (mt) begin
      mod_vec[3:1] = c[3:1]; // [R12] [R11]
    end
    if (mc) begin
      mod_vec[0] = c[0]; // [R12] [R11]
    end
  endfunction : mod_vec

  // ----------------------------------------------------------------------
  // Bid formation.
  // ----------------------------------------------------------------------
  always_comb begin
    bids = '0;
    bids[UBIA_S_RXOK] = {ubia_sat8(rx_fill), UBIA_T_RXOK, UBIA_CHAN}; // [R1] [R2]
    bids[UBIA_S_RXER] = {ubia_sat8(rx_fill), UBIA_T_RXER, UBIA_CHAN}; // [R2]
    bids[UBIA_S_RXWD] = {ubia_sat8(rx_fill), UBIA_T_RXWD, UBIA_CHAN}; // [R2]
    bids[UBIA_S_TX]   = {ubia_sat8(tx_empty), UBIA_T_TX, UBIA_CHAN}; // [R3]

    bids[UBIA_S_BRK]  = {r_r.prio[0], UBIA_C_BRK, UBIA_CHAN}; // [R4]
    bids[UBIA_S_LPB]  = {r_r.prio[1], UBIA_C_LPB, UBIA_CHAN}; // [R4]
    bids[UBIA_S_COS]  = {r_r.prio[2], UBIA_C_COS, r_r.cos_idx}; // [R4]
    bids[UBIA_S_XON]  = {r_r.prio[3], UBIA_C_XON, UBIA_CHAN}; // [R4]
    bids[UBIA_S_CT]   = {r_r.prio[4], UBIA_C_CT, r_r.ct_idx}; // [R4]
    bids[UBIA_S_ADR]  = {r_r.prio[5], UBIA_C_ADR, UBIA_CHAN}; // [R4]

    active = r_r.evt & UBIA_EVT_MASK;
    active[UBIA_S_RXOK] = ubia_trig(r_r.rx_trig, rx_fill) & ~rx_error_present; // [R20]
    active[UBIA_S_RXER] = ubia_trig(r_r.rx_trig, rx_fill) & rx_error_present; // [R20]
    active[UBIA_S_TX]   = ubia_trig(r_r.tx_trig, tx_empty); // [R20]
  end

  ubia_bid_max #(
    .N (UBIA_NSRC),
    .W (UBIA_BIDW)
  ) u_max (
    .bids      (r_r.snap_b),
    .valid     (r_r.snap_v),
    .threshold (r_r.thr),
    .max_bid   (arb_max),
    .hit       (arb_hit)
  );

  // ----------------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------------
  always_comb begin
    logic                 req;
    logic                 done_wr;
    logic                 done_rd;
    logic                 ack_start;
    logic                 upd;
    logic [UBIA_NSRC-1:0] set;
    logic [UBIA_NSRC-1:0] clr;
    logic [31:0]          rd;

    req       = avs_read | avs_write;
    done_wr   = avs_write & r_r.bus_ack;
    done_rd   = avs_read & r_r.bus_ack;
    ack_start = 1'b0;
    upd       = 1'b0;
    set       = '0;
    clr       = '0;
    rd        = '0;
    r_nxt     = r_r;
    r_nxt.bus_ack = req & ~r_r.bus_ack;

    if (avs_write && !r_r.bus_ack) begin
      r_nxt.wdat = avs_writedata[7:0];
    end

    // ----------------------------------------------------------------------
    // Acknowledge synchroniser.
    // ----------------------------------------------------------------------
    r_nxt.ack_s1 = ~interrupt_ack_n;
    r_nxt.ack_s2 = r_r.ack_s1;
    r_nxt.ack_s3 = r_r.ack_s2;

    if (r_r.ack_s2 == r_r.ack_s3) begin
      r_nxt.ack_act = r_r.ack_s3;
      ack_start     = r_r.ack_s3 & ~r_r.ack_act;
    end

    // ----------------------------------------------------------------------
    // Event flags.
    // ----------------------------------------------------------------------
    r_nxt.brk_prev = break_level;
    set[UBIA_S_BRK] = break_level ^ r_r.brk_prev; // [R19]
    set[UBIA_S_RXWD] = rx_timeout_evt;
    set[UBIA_S_LPB]  = loopback_err_evt;
    set[UBIA_S_COS]  = cos_evt;
    set[UBIA_S_XON]  = xon_evt;
    set[UBIA_S_CT]   = ct_evt;
    set[UBIA_S_ADR]  = addr_evt;

    if (cos_evt) begin
      r_nxt.cos_idx = cos_port;
    end
    if (ct_evt) begin
      r_nxt.ct_idx = ct_index;
    end

    // ----------------------------------------------------------------------
    // Register writes.
    // ----------------------------------------------------------------------
    if (done_wr) begin
      if (avs_address == UBIA_A_CTRL) begin
        r_nxt.thr     = avs_writedata[7:0];
        r_nxt.vm_type = avs_writedata[8];
        r_nxt.vm_chan = avs_writedata[9];
      end else if (avs_address == UBIA_A_MASK) begin
        r_nxt.mask = avs_writedata[UBIA_NSRC-1:0];
      end else if (avs_address == UBIA_A_STAT) begin
        clr = avs_writedata[UBIA_NSRC-1:0] & UBIA_EVT_MASK;
      end else if (avs_address == UBIA_A_UPD) begin
        upd = 1'b1;
      end else if (avs_address == UBIA_A_VEC) begin
        r_nxt.vec = avs_writedata[7:0];
      end else if (avs_address == UBIA_A_PRIOA) begin
        r_nxt.prio[0] = avs_writedata[6:0];
        r_nxt.prio[1] = avs_writedata[14:8];
        r_nxt.prio[2] = avs_writedata[22:16];
        r_nxt.prio[3] = avs_writedata[30:24];
      end else if (avs_address == UBIA_A_PRIOB) begin
        r_nxt.prio[4] = avs_writedata[6:0];
        r_nxt.prio[5] = avs_writedata[14:8];
      end else if (avs_address == UBIA_A_TRIG) begin
        r_nxt.rx_trig = avs_writedata[1:0];
        r_nxt.tx_trig = avs_writedata[3:2];
      end
    end

    r_nxt.evt = ((r_r.evt & ~clr) | set) & UBIA_EVT_MASK;

    // Phase 0 freezes the bids; phase 1 resolves them.
    r_nxt.phase = ~r_r.phase; // [R7]

    if (!r_r.phase) begin
      r_nxt.snap_b = bids; // [R8]
      r_nxt.snap_v = active & r_r.mask; // [R6] [R8]
    end else begin
      r_nxt.win = arb_hit ? arb_max : '0; // [R7] [R11]
      r_nxt.irq = arb_hit; // [R5] [R21]
    end

    if (ack_start || upd) begin
      r_nxt.cap = r_r.win; // [R9] [R10] [R11]
    end

    r_nxt.vec_out = mod_vec(r_r.vec, r_nxt.cap, r_r.vm_type, r_r.vm_chan); // [R12]

    // ----------------------------------------------------------------------
    // Register reads.
    // ----------------------------------------------------------------------
    if (avs_address == UBIA_A_CTRL) begin
      rd = {22'h0, r_r.vm_chan, r_r.vm_type, r_r.thr};
    end else if (avs_address == UBIA_A_MASK) begin
      rd = 32'(r_r.mask);
    end else if (avs_address == UBIA_A_STAT) begin
      rd = 32'(active);
    end else if (avs_address == UBIA_A_CAP || avs_address == UBIA_A_GCAP) begin
      rd = 32'(r_r.cap); // [R13]
    end else if (avs_address == UBIA_A_VEC) begin
      rd = 32'(r_r.vec);
    end else if (avs_address == UBIA_A_PRIOA) begin
      rd = {1'h0, r_r.prio[3], 1'h0, r_r.prio[2], 1'h0, r_r.prio[1], 1'h0, r_r.prio[0]};
    end else if (avs_address == UBIA_A_PRIOB) begin
      rd = {17'h0, r_r.prio[5], 1'h0, r_r.prio[4]};
    end else if (avs_address == UBIA_A_TRIG) begin
      rd = {28'h0, r_r.tx_trig, r_r.rx_trig};
    end else if (avs_address == UBIA_A_GBC) begin
      if (cap_is_rx(r_r.cap)) begin
        rd = 32'(ubia_sat8(rx_fill)); // [R14]
      end else if (r_r.cap[3:1] == UBIA_T_TX) begin
        rd = 32'(ubia_sat8(tx_empty)); // [R14]
      end
    end else if (avs_address == UBIA_A_GCH || avs_address == UBIA_A_GCHA) begin
      if (r_r.cap[4:1] == UBIA_C_CT || r_r.cap[4:1] == UBIA_C_COS) begin
        rd = 32'(r_r.cap[0]); // [R15]
      end
    end else if (avs_address == UBIA_A_GTYP) begin
      rd = 32'(r_r.cap[4:1]); // [R13]
    end else if (avs_address == UBIA_A_GRX) begin
      if (cap_is_rx(r_r.cap)) begin
        rd = 32'(rx_data); // [R16]
      end
    end else if (avs_address == UBIA_A_GCNT) begin
      rd = 32'(r_r.cap[11:4]);
    end else if (avs_address == UBIA_A_GVEC) begin
      rd = 32'(r_r.vec_out);
    end else if (avs_address == UBIA_A_GSTM) begin
      rd = 32'(active & r_r.mask);
    end

    if (req && !r_r.bus_ack) begin
      r_nxt.rdata = rd;
    end

    rx_pop  = done_rd & (avs_address == UBIA_A_GRX) & cap_is_rx(r_r.cap); // [R16]
    tx_push = done_wr & (avs_address == UBIA_A_GTX) & (r_r.cap[3:1] == UBIA_T_TX); // [R13]
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      r_r     <= '0;
      r_r.vec <= UBIA_VEC_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign avs_readdata        = r_r.rdata;
  assign avs_waitrequest     = (avs_read | avs_write) & ~r_r.bus_ack;
  assign interrupt_request_n = ~r_r.irq; // [R5]
  assign vector_out          = r_r.vec_out;
  assign vector_oe           = r_r.ack_act; // [R12]
  assign tx_wdata            = r_r.wdat;
endmodule : ubia_top

// ==== verif/ubia_host_model.sv ====
`timescale 1ns/1ps
module ubia_host_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       interrupt_request_n,
  input  wire logic       enable,
  input  wire logic [3:0] delay,
  output logic            interrupt_ack_n
);
  logic [4:0] cnt_r;

  // The host acknowledges a request once, ten cycles long, after a delay.
  always_ff @(posedge clk) begin
    if (srst || !enable) begin
      cnt_r           <= 5'h00;
      interrupt_ack_n <= 1'b1;
    end else begin
      if ((!interrupt_request_n || cnt_r != 5'h00) && cnt_r != 5'h1f) begin
        cnt_r <= cnt_r + 5'h01;
      end
      interrupt_ack_n <= !(cnt_r > {1'b0, delay} && cnt_r <= {1'b0, delay} + 5'h0a);
    end
  end
endmodule : ubia_host_model

// ==== verif/ubia_top_monitor.sv ====
`timescale 1ns/1ps
module ubia_top_monitor (
  input wire logic                          clk,
  input wire logic                          srst,
  input wire logic [ubia_pkg::UBIA_AW-1:0]  avs_address,
  input wire logic                          avs_read,
  input wire logic                          avs_write,
  input wire logic [31:0]                   avs_writedata,
  input wire logic                          avs_waitrequest,
  input wire logic                          interrupt_request_n,
  input wire logic                          interrupt_ack_n,
  input wire logic [7:0]                    vector_out,
  input wire logic                          vector_oe,
  input wire logic                          rx_pop,
  input wire logic                          tx_push,
  input wire logic [7:0]                    tx_wdata
);
  import ubia_pkg::*;
  logic [3:0] quiet_r;
  logic [3:0] quiet_nxt;

  // Counts cycles since the last write or acknowledge.
  always_comb begin
    quiet_nxt = (quiet_r == 4'hf) ? quiet_r : quiet_r + 4'h1;
    if (avs_write || !interrupt_ack_n) quiet_nxt = 4'h0;
  end
  always_ff @(posedge clk) begin
    if (srst) quiet_r <= 4'h0;
    else quiet_r <= quiet_nxt;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("waitrequest longer than one cycle");
  a_irq_half_rate: assert property ($changed(interrupt_request_n)
    |=> $stable(interrupt_request_n)) else $error("request changed on two cycles");
  a_ack_raises_oe: assert property ($fell(interrupt_ack_n) ##0 (!interrupt_ack_n)[*7]
    |-> vector_oe) else $error("vector not driven during acknowledge");
  a_idle_drops_oe: assert property (interrupt_ack_n[*7] |-> !vector_oe)
    else $error("vector driven without acknowledge");
  a_vector_holds: assert property (quiet_r >= 4'h4 |-> $stable(vector_out))
    else $error("vector changed without capture");
  a_pop_source: assert property (rx_pop |-> avs_read && !avs_waitrequest
    && avs_address == UBIA_A_GRX) else $error("receive pop without port read");
  a_pop_single: assert property (rx_pop |=> !rx_pop)
    else $error("receive pop longer than one cycle");
  a_push_source: assert property (tx_push |-> avs_write && !avs_waitrequest
    && avs_address == UBIA_A_GTX && tx_wdata == avs_writedata[7:0])
    else $error("transmit push without port write");

  c_irq: cover property ($fell(interrupt_request_n));
  c_oe: cover property ($rose(vector_oe));
  c_pop: cover property (rx_pop);
endmodule : ubia_top_monitor

bind ubia_top ubia_top_monitor ubia_top_monitor_inst (.clk, .srst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_waitrequest, .interrupt_request_n, .interrupt_ack_n,
  .vector_out, .vector_oe, .rx_pop, .tx_push, .tx_wdata);

// ==== verif/test_ubia_top.sv ====
`timescale 1ns/1ps
module test_ubia_top;
  import ubia_pkg::*;
  logic                clk, srst, avs_read, avs_write, avs_waitrequest, host_en;
  logic [UBIA_AW-1:0]  avs_address;
  logic [31:0]         avs_writedata, avs_readdata;
  logic                interrupt_request_n, interrupt_ack_n, vector_oe, rx_pop, tx_push;
  logic [7:0]          vector_out, rx_data, tx_wdata;
  logic [8:0]          rx_fill, tx_empty;
  logic                rx_error_present, rx_timeout_evt, break_level, loopback_err_evt;
  logic                cos_evt, cos_port, xon_evt, ct_evt, ct_index, addr_evt;
  logic [3:0]          host_delay;
  int                  mismatches, num_checks, cycles, pops, pushes;
  logic [7:0]          pushed;

  ubia_top ubia_top_inst (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .interrupt_request_n, .interrupt_ack_n, .vector_out,
    .vector_oe, .rx_fill, .rx_error_present, .rx_timeout_evt, .rx_data, .rx_pop, .tx_empty,
    .tx_push, .tx_wdata, .break_level, .loopback_err_evt, .cos_evt, .cos_port, .xon_evt,
    .ct_evt, .ct_index, .addr_evt);
  ubia_host_model ubia_host_model_inst (.clk, .srst, .interrupt_request_n, .enable(host_en),
    .delay(host_delay), .interrupt_ack_n);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles = cycles + 1;
    pops   = pops + int'(rx_pop);
    pushes = pushes + int'(tx_push);
    if (tx_push) pushed = tx_wdata;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
    if (n >= 40) check("bus wait", 32'h1, 32'h0);
  endtask : bus

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input string nm, input logic [6:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(nm, q, exp);
  endtask : rd

  task automatic upd_rd(input string nm, input logic [31:0] exp);
    repeat (6) @(posedge clk);
    wr(UBIA_A_UPD, 32'h0);
    rd(nm, UBIA_A_CAP, exp);
  endtask : upd_rd

  task automatic fire(input int i);
    case (i)
      0: break_level <= !break_level;
      1: loopback_err_evt <= 1'b1;
      2: cos_evt <= 1'b1;
      3: xon_evt <= 1'b1;
      4: ct_evt <= 1'b1;
      default: addr_evt <= 1'b1;
    endcase
    @(posedge clk);
    {loopback_err_evt, cos_evt, xon_evt, ct_evt, addr_evt} <= 5'h00;
    repeat (6) @(posedge clk);
  endtask : fire

  task automatic t_regs();
    check("irq reset", 32'(interrupt_request_n), 32'h1);
    rd("ctrl reset", UBIA_A_CTRL, 32'h0);
    wr(UBIA_A_CTRL, 32'h3ff);
    rd("ctrl", UBIA_A_CTRL, 32'h3ff);
    wr(UBIA_A_CTRL, 32'h0);
    wr(7'h7c, 32'hffff_ffff);
    rd("unmapped", 7'h7c, 32'h0);
    wr(UBIA_A_CAP, 32'hfff);
    rd("cap ro", UBIA_A_CAP, 32'h0);
  endtask : t_regs

  task automatic t_poll();
    rx_fill <= 9'h005;
    wr(UBIA_A_MASK, 32'h1);
    upd_rd("cap rx", 32'h052);
    rd("gbc", UBIA_A_GBC, 32'h5);
    rd("gtyp", UBIA_A_GTYP, {28'h0, 1'b1, UBIA_T_RXOK});
    rd("grx", UBIA_A_GRX, 32'h5a);
    check("pops", pops, 32'h1);
    rx_fill <= 9'h100;
    rx_error_present <= 1'b1;
    wr(UBIA_A_MASK, 32'h3);
    rd("cap hold", UBIA_A_CAP, 32'h052);
    upd_rd("cap err", 32'hffa);
    rx_error_present <= 1'b0;
    wr(UBIA_A_MASK, 32'h4);
    rx_timeout_evt <= 1'b1;
    @(posedge clk);
    rx_timeout_evt <= 1'b0;
    upd_rd("cap wd", 32'hff8);
    wr(UBIA_A_MASK, 32'h0);
    upd_rd("cap none", 32'h0);
  endtask : t_poll

  task automatic t_level();
    rx_fill <= 9'h005;
    wr(UBIA_A_MASK, 32'h1);
    wr(UBIA_A_CTRL, 32'h05);
    repeat (5) @(posedge clk);
    check("irq above", 32'(interrupt_request_n), 32'h0);
    wr(UBIA_A_CTRL, 32'h06);
    repeat (4) @(posedge clk);
    check("irq below", 32'(interrupt_request_n), 32'h1);
    upd_rd("cap below", 32'h0);
    wr(UBIA_A_CTRL, 32'h0);
    wr(UBIA_A_TRIG, 32'h1);
    rx_fill <= 9'h07f;
    upd_rd("trig low", 32'h0);
    rx_fill <= 9'h080;
    upd_rd("trig met", 32'h802);
    wr(UBIA_A_TRIG, 32'h0);
    rx_fill <= 9'h000;
    tx_empty <= 9'h080;
    wr(UBIA_A_MASK, 32'h8);
    upd_rd("cap tx", 32'h804);
    rd("gbc tx", UBIA_A_GBC, 32'h80);
    wr(UBIA_A_GTX, 32'h1c3);
    check("pushes", pushes, 32'h1);
    check("push data", {24'h0, pushed}, 32'hc3);
    tx_empty <= 9'h000;
  endtask : t_level

  task automatic t_events();
    logic [3:0] code [6];
    logic [6:0] pri;
    logic       idx;
    code = '{UBIA_C_BRK, UBIA_C_LPB, UBIA_C_COS, UBIA_C_XON, UBIA_C_CT, UBIA_C_ADR};
    cos_port <= 1'b1;
    ct_index <= 1'b1;
    wr(UBIA_A_PRIOA, 32'h4433_2211);
    wr(UBIA_A_PRIOB, 32'h0000_6655);
    for (int i = 0; i < 6; i++) begin
      pri = 7'((i + 1) * 17);
      idx = (i == 2 || i == 4);
      wr(UBIA_A_STAT, 32'h3f4);
      wr(UBIA_A_MASK, 32'h1 << (i + 4));
      fire(i);
      check("irq evt", 32'(interrupt_request_n), 32'h0);
      upd_rd("cap evt", {20'h0, pri, code[i], idx});
      rd("gch", UBIA_A_GCH, {31'h0, idx});
      rd("gtyp", UBIA_A_GTYP, {28'h0, code[i]});
    end
    wr(UBIA_A_STAT, 32'h3f4);
    fire(0);
    rd("brk end", UBIA_A_STAT, 32'h10);
  endtask : t_events

  task automatic t_ack();
    int n;
    rx_fill <= 9'h005;
    wr(UBIA_A_VEC, 32'haf);
    wr(UBIA_A_CTRL, 32'h300);
    wr(UBIA_A_MASK, 32'h1);
    for (int k = 0; k < 2; k++) begin
      host_delay <= (k == 0) ? 4'h0 : 4'h9;
      host_en <= 1'b1;
      n = 0;
      while (vector_oe !== 1'b1 && n < 60) begin
        @(posedge clk);
        n++;
      end
      repeat (2) @(posedge clk);
      check("vector", {24'h0, vector_out}, 32'ha2);
      repeat (20) @(posedge clk);
      host_en <= 1'b0;
      rd("cap ack", UBIA_A_CAP, 32'h052);
    end
    wr(UBIA_A_CTRL, 32'h0);
    rd("vec plain", UBIA_A_GVEC, 32'haf);
    wr(UBIA_A_CTRL, 32'h300);
    wr(UBIA_A_MASK, 32'h0);
    upd_rd("cap zero", 32'h0);
    rd("vec none", UBIA_A_GVEC, 32'ha0);
  endtask : t_ack

  initial begin
    {srst, avs_read, avs_write, host_en} = 4'h8;
    {avs_address, avs_writedata, host_delay} = '0;
    {rx_fill, tx_empty, rx_data} = {9'h000, 9'h000, 8'h5a};
    {rx_error_present, rx_timeout_evt, break_level, loopback_err_evt} = 4'h0;
    {cos_evt, cos_port, xon_evt, ct_evt, ct_index, addr_evt} = 6'h00;
    {mismatches, num_checks, cycles, pops, pushes} = '0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_poll();
    t_level();
    t_events();
    t_ack();
    summarize();
  end
endmodule : test_ubia_top
